// >>> bench/smpc_checker.sv
// port-level assertions of the stop mode power controller
`timescale 1ns/1ps
`default_nettype none
module smpc_checker #(
   parameter int OSC_CYCLES = 4
) (
   // clock and reset
   input wire logic       hclk,
   input wire logic       hresetn,
   // cpu side and wake pins
   input wire logic       stop_exec,
   input wire logic       reset_pin_n,
   input wire logic       irq_pin,
   input wire logic [7:0] keyboard_interrupt_pins,
   // design outputs
   input wire logic [7:0] pad_out,
   input wire logic       core_power_off,
   input wire logic       regulator_standby,
   input wire logic       adc_standby,
   input wire logic       clock_halt,
   input wire logic       clock_gen_off,
   input wire logic       cpu_reset,
   input wire logic       periph_reset,
   input wire logic       wake_interrupt
);
   // one clock domain, held off during reset
   default clocking dcb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // ****
   // assertions
   // ****
   a_deep_power_down: assert property (core_power_off |-> regulator_standby && adc_standby && clock_halt)
      else $error("deep stop without full power down");
   a_halt_group: assert property (clock_halt |-> clock_gen_off && regulator_standby && adc_standby)
      else $error("halted clocks without generator off and standby");
   a_stop_cause: assert property ($rose(clock_halt) |-> $past(stop_exec))
      else $error("stop entered without a stop instruction");
   a_pads_frozen: assert property (core_power_off && $past(core_power_off) |-> $stable(pad_out))
      else $error("pads moved while latched in deep stop");
   a_deep_exit: assert property (core_power_off && (!reset_pin_n || !irq_pin) |=> !core_power_off)
      else $error("deep stop ignored a wake pin");
   a_deep_restart: assert property ($fell(core_power_off) |=> cpu_reset && periph_reset)
      else $error("deep wake without restart pulse");
   a_shallow_exit: assert property (clock_halt && !core_power_off && |keyboard_interrupt_pins |=> !clock_halt)
      else $error("shallow stop ignored keyboard wake");
   a_exit_vector: assert property ($fell(clock_halt) |-> (wake_interrupt && !cpu_reset) or
      (!wake_interrupt ##1 (cpu_reset && !wake_interrupt)))
      else $error("stop exit without exactly one of restart or vector");
   a_single_pulse: assert property (cpu_reset || wake_interrupt |=> !cpu_reset && !wake_interrupt)
      else $error("restart or vector pulse longer than one cycle");
   // main scenarios reached
   c_deep_entry: cover property ($rose(core_power_off));
   c_vector: cover property (wake_interrupt);
   c_restart: cover property (cpu_reset && periph_reset);
endmodule

bind smpc_top smpc_checker #(.OSC_CYCLES(OSC_CYCLES)) i_smpc_checker (
   .hclk, .hresetn, .stop_exec, .reset_pin_n, .irq_pin, .keyboard_interrupt_pins, .pad_out,
   .core_power_off, .regulator_standby, .adc_standby, .clock_halt, .clock_gen_off, .cpu_reset,
   .periph_reset, .wake_interrupt
);
`default_nettype wire

// >>> bench/smpc_partner.sv
// far side model: wake pins and the software owning the port registers
`timescale 1ns/1ps
`default_nettype none
module smpc_partner (
   // clock, reset and bench commands
   input  wire logic       hclk,
   input  wire logic       hresetn,
   input  wire logic [1:0] op,
   input  wire logic [7:0] arg,
   // device events
   input  wire logic       stop_exec,
   input  wire logic       cpu_reset,
   // wake pins
   output logic            reset_pin_n,
   output logic            irq_pin,
   output logic [7:0]      keyboard_interrupt_pins,
   // port registers
   output logic [7:0]      port_out,
   output logic [7:0]      port_oe
);
   logic [7:0] ram;
   logic [1:0] kind;
   logic       act;
   // a pin is active for one cycle, then released to its pull-up or pull-down
   assign reset_pin_n = !(act && kind == 2'h2);
   assign irq_pin = !(act && kind == 2'h1);
   assign keyboard_interrupt_pins = {7'h0, act && kind == 2'h0};
   // ****
   // software and pin sequencing
   // ****
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         {ram, kind, act, port_out, port_oe} <= '0;
      end else begin
         act <= op == 2'h3;
         if (op == 2'h3) kind <= arg[1:0];
         if (stop_exec) ram <= port_out;
         if (cpu_reset) {port_out, port_oe} <= '0;
         else if (op == 2'h1) {port_out, port_oe} <= {arg, 8'hFF};
         else if (op == 2'h2) port_out <= ram;
      end
   end
endmodule
`default_nettype wire

// >>> bench/smpc_top_tb.sv
// self-checking bench of the stop mode power controller
`timescale 1ns/1ps
`default_nettype none
`include "smpc_cfg.svh"
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin fail_count++; \
   $display("Error %s expected %h seen %h", nm, ex, got); end end
module smpc_top_tb;
   logic        hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0, stop_exec = 1'h0;
   logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
   logic [1:0]  htrans = '0, op = '0;
   logic [7:0]  arg = '0, periph_en = '0, periph_out = '0, periph_oe = '0;
   logic [7:0]  keyboard_interrupt_pins, port_out, port_oe, pad_out, pad_oe;
   logic        hreadyout, hresp, reset_pin_n, irq_pin, core_power_off, regulator_standby, adc_standby;
   logic        clock_halt, clock_gen_off, cpu_reset, wake_interrupt, irq;
   int          fail_count = 0, n_tests = 0;
   typedef struct packed { logic [7:0] a; logic [31:0] d; logic [31:0] e; } smpc_row_s;
   smpc_row_s   rows [5] = '{'{8'h00, 32'h7F, 32'h7F}, '{8'h10, 32'hFF, 32'hF}, '{8'h04, 32'h2, 32'h0},
                             '{8'h14, 32'hFFFFFFFF, 32'h0}, '{8'h00, 32'h6, 32'h6}};
   // free-running 250 MHz clock
   always #2 hclk = ~hclk;
   // design, far side model
   smpc_top #(.OSC_CYCLES(4)) i_smpc_top (
      .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout),
      .hrdata, .hreadyout, .hresp, .stop_exec, .reset_pin_n, .irq_pin, .keyboard_interrupt_pins,
      .port_out, .port_oe, .periph_en, .periph_out, .periph_oe, .pad_out, .pad_oe, .core_power_off,
      .regulator_standby, .adc_standby, .clock_halt, .clock_gen_off, .cpu_reset, .periph_reset(),
      .wake_interrupt, .irq
   );
   smpc_partner i_smpc_partner (
      .hclk, .hresetn, .op, .arg, .stop_exec, .cpu_reset, .reset_pin_n, .irq_pin,
      .keyboard_interrupt_pins, .port_out, .port_oe
   );
   // ****
   // tasks
   // ****
   task automatic tick(input int n);
      repeat (n) @(posedge hclk);
   endtask
   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // waits for hready high at an edge, bounded
   task automatic wait_rdy;
      int i;
      i = 0;
      do begin
         @(posedge hclk);
         i++;
      end while (hreadyout !== 1'h1 && i < 50);
      if (hreadyout !== 1'h1) begin fail_count++; complete_run; end
   endtask
   // one single ahb-lite word transfer
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'h1;
      haddr <= {24'h0, a};
      hwrite <= w;
      htrans <= 2'h2;
      wait_rdy;
      hsel <= 1'h0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy;
      rd = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'h1, a, d);
      tick(2);
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string nm);
      bus(1'h0, a, 32'h0);
      `CHK(nm, e, rd)
   endtask
   task automatic cmd(input logic [1:0] o, input logic [7:0] v);
      op <= o;
      arg <= v;
      tick(1);
      op <= 2'h0;
   endtask
   task automatic stop_pulse;
      stop_exec <= 1'h1;
      tick(1);
      stop_exec <= 1'h0;
   endtask
   // waits for the restart or the vector pulse, bounded
   task automatic wait_pulse(input logic r);
      int i;
      for (i = 0; i < 300; i++) begin
         @(posedge hclk);
         if ((r ? cpu_reset : wake_interrupt) === 1'h1) break;
      end
      `CHK("other pulse", 1'h0, r ? wake_interrupt : cpu_reset)
      if (i == 300) begin fail_count++; complete_run; end
   endtask
   task automatic do_reset;
      hresetn <= 1'h0;
      tick(12);
      hresetn <= 1'h1;
      tick(1);
   endtask
   // ****
   // main sequence
   // ****
   initial begin
      do_reset;
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].d);
         rchk(rows[i].a, rows[i].e, "row");
      end
      `CHK("okay", 1'h0, hresp)
      do_reset;
      rchk(`SMPC_OFS_CONTROL, 32'h6, "ctl reset");
      rchk(`SMPC_OFS_INT_ENABLE, 32'h0, "en reset");
      // refused deep stop raises an interrupt, masked then cleared
      wr(`SMPC_OFS_CONTROL, 32'h7);
      wr(`SMPC_OFS_INT_ENABLE, 32'h4);
      stop_pulse;
      tick(3);
      `CHK("refused", 1'h0, core_power_off)
      `CHK("irq set", 1'h1, irq)
      wr(`SMPC_OFS_INT_ENABLE, 32'h0);
      `CHK("irq masked", 1'h0, irq)
      wr(`SMPC_OFS_INT_ENABLE, 32'h4);
      `CHK("irq again", 1'h1, irq)
      wr(`SMPC_OFS_INT_CLEAR, 32'h4);
      `CHK("irq cleared", 1'h0, irq)
      rchk(`SMPC_OFS_INT_STATUS, 32'h0, "status");
      // deep stop, woken by irq then by reset pin, without and with port restore
      for (int k = 0; k < 2; k++) begin
         cmd(2'h1, 8'hA5);
         wr(`SMPC_OFS_CONTROL, 32'h43);
         stop_pulse;
         tick(2);
         `CHK("power off", 1'h1, core_power_off)
         `CHK("standby", 1'h1, regulator_standby & adc_standby)
         cmd(2'h1, 8'h00);
         tick(3);
         `CHK("still deep", 1'h1, core_power_off)
         `CHK("latched", 8'hA5, pad_out)
         `CHK("latched oe", 8'hFF, pad_oe)
         cmd(2'h3, k ? 8'h2 : 8'h1);
         wait_pulse(1'h1);
         rchk(`SMPC_OFS_CONTROL, 32'h6, "ctl restart");
         rchk(`SMPC_OFS_PMSC2, 32'h5, "wake flag");
         `CHK("held", 8'hA5, pad_out)
         if (k) cmd(2'h2, 8'h00);
         wr(`SMPC_OFS_PMSC2, 32'h2);
         rchk(`SMPC_OFS_PMSC2, 32'h0, "ack");
         `CHK("pads open", k ? 8'hA5 : 8'h00, pad_out)
      end
      periph_en <= 8'hF0;
      periph_out <= 8'h3C;
      periph_oe <= 8'hFF;
      tick(3);
      `CHK("pad mix", 8'h35, pad_out)
      `CHK("pad oe mix", 8'hF0, pad_oe)
      // shallow stop woken by keyboard, irq, reset pin and periodic tick
      for (int k = 0; k < 4; k++) begin
         wr(`SMPC_OFS_CONTROL, (k == 3) ? 32'h8 : 32'h0);
         stop_pulse;
         tick(2);
         `CHK("halt", 2'h3, {clock_halt, clock_gen_off})
         `CHK("no latch", 1'h0, core_power_off)
         if (k < 3) begin
            tick(40);
            `CHK("tick off", 1'h1, clock_halt)
            cmd(2'h3, 8'(k));
         end
         wait_pulse(k == 2);
         rchk(`SMPC_OFS_CONTROL, k == 2 ? 32'h6 : (k == 3 ? 32'h8 : 32'h0), "kept");
      end
      // shallow stop with irq active high: the idle-high pin wakes at once
      wr(`SMPC_OFS_CONTROL, 32'h40);
      stop_pulse;
      wait_pulse(1'h0);
      rchk(`SMPC_OFS_CONTROL, 32'h40, "irq high kept");
      complete_run;
   end
endmodule
`default_nettype wire

// >>> design/smpc_rti_timer.sv
// ~1 kHz source divided down from hclk, stopped while rate select is 0, and periodic wake timer
`timescale 1ns/1ps
`default_nettype none
`include "smpc_cfg.svh"

module smpc_rti_timer #(
   parameter int OSC_CYCLES = `SMPC_RTI_OSC_CYCLES
) (
   // clock and reset
   input  wire logic       hclk,
   input  wire logic       hresetn,
   // rate select, 0 disables
   input  wire logic [2:0] rate_sel,
   // periodic wake pulse
   output logic            rti_tick
);

   typedef struct packed {
      logic [`SMPC_OSC_CNT_W-1:0] osc_cnt;
      logic [`SMPC_RTI_CNT_W-1:0] per_cnt;
      logic                       tick;
   } smpc_rti_s;

   smpc_rti_s r;
   smpc_rti_s next_r;

   // period in 1 kHz ticks for a rate select: 4, 8, ... 256
   function automatic logic [`SMPC_RTI_CNT_W-1:0] smpc_period(input logic [2:0] sel);
      smpc_period = `SMPC_RTI_CNT_W'(1) << ({1'b0, sel} + 4'h1);
   endfunction

   // source runs only while a rate is selected
   always_comb begin
      next_r      = r;
      next_r.tick = 1'b0;
      if (rate_sel == 3'h0) begin
         next_r.osc_cnt = '0;
         next_r.per_cnt = '0;
      end else if (r.osc_cnt == `SMPC_OSC_CNT_W'(OSC_CYCLES - 1)) begin
         next_r.osc_cnt = '0;
         if (r.per_cnt >= smpc_period(rate_sel) - `SMPC_RTI_CNT_W'(1)) begin
            next_r.per_cnt = '0;
            next_r.tick    = 1'b1;
         end else begin
            next_r.per_cnt = r.per_cnt + `SMPC_RTI_CNT_W'(1);
         end
      end else begin
         next_r.osc_cnt = r.osc_cnt + `SMPC_OSC_CNT_W'(1);
      end
   end

   // state register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign rti_tick = r.tick;

endmodule
`default_nettype wire

// >>> design/smpc_top.sv
// stop mode power controller: deep and shallow stop sequencing, pin latches, wake logic, registers
// ************************************************************
// ************************************************************
`timescale 1ns/1ps
`default_nettype none
`include "smpc_cfg.svh"

module smpc_top #(
   parameter int OSC_CYCLES = `SMPC_RTI_OSC_CYCLES
) (
   // clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // ahb-lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // cpu side
   input  wire logic        stop_exec,
   // wake pins
   input  wire logic        reset_pin_n,
   input  wire logic        irq_pin,
   input  wire logic [7:0]  keyboard_interrupt_pins,
   // pin drivers from port registers and peripherals
   input  wire logic [7:0]  port_out,
   input  wire logic [7:0]  port_oe,
   input  wire logic [7:0]  periph_en,
   input  wire logic [7:0]  periph_out,
   input  wire logic [7:0]  periph_oe,
   // pads
   output logic [7:0]       pad_out,
   output logic [7:0]       pad_oe,
   // power and clock controls
   output logic             core_power_off,
   output logic             regulator_standby,
   output logic             adc_standby,
   output logic             clock_halt,
   output logic             clock_gen_off,
   // cpu restart and vectoring
   output logic             cpu_reset,
   output logic             periph_reset,
   output logic             wake_interrupt,
   // interrupt
   output logic             irq
);
   import smpc_pkg::*;

   smpc_state_s r;
   smpc_state_s next_r;
   logic        rti_tick;
   logic        addr_rd;
   logic        addr_wr;
   logic        wr_ctrl;
   logic        wr_pm;
   logic        wr_clear;
   logic        wr_enable;
   logic        lvd_armed;
   logic        deep_wake;
   logic        shallow_irq;
   logic        shallow_wake;
   logic [3:0]  ev;

   // ************************************************************
   // periodic wake source
   // ************************************************************
   smpc_rti_timer #(
      .OSC_CYCLES (OSC_CYCLES)
   ) u_rti (
      .hclk     (hclk),
      .hresetn  (hresetn),
      .rate_sel (r.ctrl[`SMPC_CTL_RATE_HI:`SMPC_CTL_RATE_LO]),
      .rti_tick (rti_tick)
   );

   // ************************************************************
   // bus decode
   // ************************************************************

   // address phase qualifiers and data phase write strobes
   assign addr_rd   = hsel & hready & htrans[1] & ~hwrite;
   assign addr_wr   = hsel & hready & htrans[1] & hwrite;
   assign wr_ctrl   = r.wr_pend & (r.wr_addr == `SMPC_OFS_CONTROL);
   assign wr_pm     = r.wr_pend & (r.wr_addr == `SMPC_OFS_PMSC2);
   assign wr_clear  = r.wr_pend & (r.wr_addr == `SMPC_OFS_INT_CLEAR);
   assign wr_enable = r.wr_pend & (r.wr_addr == `SMPC_OFS_INT_ENABLE);

   // ************************************************************
   // wake and entry conditions
   // ************************************************************

   // detector counts as armed in stop only if both enables are set
   assign lvd_armed    = r.ctrl[`SMPC_CTL_LVD_EN] & r.ctrl[`SMPC_CTL_LVD_STOP_EN];
   // deep stop: irq is low-active whatever the polarity bit says
   assign deep_wake    = ~reset_pin_n | ~irq_pin | rti_tick;
   // shallow stop: irq honours the configured polarity
   assign shallow_irq  = (irq_pin == r.ctrl[`SMPC_CTL_IRQ_HIGH]) | (|keyboard_interrupt_pins) | rti_tick;
   assign shallow_wake = ~reset_pin_n | shallow_irq;

   // read data for an offset
   function automatic logic [31:0] smpc_read(input smpc_state_s s, input logic [7:0] a);
      logic [31:0] d;
      d = 32'h0000_0000;
      unique case (a)
         `SMPC_OFS_CONTROL:    d[`SMPC_CTL_WIDTH-1:0] = s.ctrl;
         `SMPC_OFS_PMSC2: begin
            d[`SMPC_PM_WAKE_FLAG] = s.wake_flag;
            d[`SMPC_PM_LATCHED]   = s.latched;
         end
         `SMPC_OFS_INT_STATUS: d[`SMPC_EV_WIDTH-1:0] = s.int_status;
         `SMPC_OFS_INT_ENABLE: d[`SMPC_EV_WIDTH-1:0] = s.int_enable;
         default:              d = 32'h0000_0000;
      endcase
      return d;
   endfunction

   // ************************************************************
   // next state
   // ************************************************************
   always_comb begin
      next_r                = r;
      ev                    = 4'h0;
      next_r.cpu_reset      = 1'b0;
      next_r.periph_reset   = 1'b0;
      next_r.wake_interrupt = 1'b0;

      // bus address phase, zero wait states
      next_r.wr_pend = addr_wr;
      if (addr_wr) begin
         next_r.wr_addr = haddr[7:0];
      end
      if (addr_rd) begin
         next_r.hrdata = smpc_read(r, haddr[7:0]);
      end

      // register writes in the data phase
      if (wr_ctrl) begin
         next_r.ctrl = hwdata[`SMPC_CTL_WIDTH-1:0];
      end
      if (wr_enable) begin
         next_r.int_enable = hwdata[`SMPC_EV_WIDTH-1:0];
      end
      if (wr_pm && hwdata[`SMPC_PM_ACK]) begin
         next_r.latched   = 1'b0;
         next_r.wake_flag = 1'b0;
      end

      // power sequencing
      unique case (r.state)
         SMPC_RUN: begin
            if (stop_exec) begin
               if (!r.ctrl[`SMPC_CTL_DEEP_SEL]) begin
                  next_r.state = SMPC_SHALLOW;
               end else if (lvd_armed) begin
                  ev[`SMPC_EV_REFUSED] = 1'b1;
               end else begin
                  next_r.state     = SMPC_DEEP;
                  next_r.latched   = 1'b1;
                  next_r.latch_out = r.pad_out;
                  next_r.latch_oe  = r.pad_oe;
               end
            end
         end
         SMPC_DEEP: begin
            if (deep_wake) begin
               next_r.state = SMPC_RESTART;
               ev[`SMPC_EV_DEEP_WAKE] = 1'b1;
               next_r.wake_flag = 1'b1;
            end
         end
         SMPC_SHALLOW: begin
            if (shallow_wake) begin
               ev[`SMPC_EV_SHALLOW_WAKE] = 1'b1;
               if (!reset_pin_n) begin
                  next_r.state = SMPC_RESTART;
               end else begin
                  next_r.state          = SMPC_RUN;
                  next_r.wake_interrupt = 1'b1;
               end
            end
         end
         SMPC_RESTART: begin
            // power-on style restart; latches and wake flag survive
            next_r.state        = SMPC_RUN;
            next_r.cpu_reset    = 1'b1;
            next_r.periph_reset = 1'b1;
            next_r.ctrl         = `SMPC_CTL_RESET;
            next_r.int_enable   = 4'h0;
         end
      endcase

      // sticky events, a set wins over a clear in the same cycle
      ev[`SMPC_EV_RTI] = rti_tick;
      if (wr_clear) begin
         next_r.int_status = r.int_status & ~hwdata[`SMPC_EV_WIDTH-1:0];
      end
      next_r.int_status = next_r.int_status | ev;
      next_r.irq        = |(next_r.int_status & next_r.int_enable);

      // power and clock controls of the next state
      next_r.core_power_off    = (next_r.state == SMPC_DEEP);
      next_r.regulator_standby = (next_r.state == SMPC_DEEP) || (next_r.state == SMPC_SHALLOW);
      next_r.adc_standby       = next_r.regulator_standby;
      next_r.clock_halt        = next_r.regulator_standby;
      next_r.clock_gen_off     = next_r.regulator_standby;

      // pad drive: latch, else peripheral if enabled, else port registers
      if (next_r.latched) begin
         next_r.pad_out = next_r.latch_out;
         next_r.pad_oe  = next_r.latch_oe;
      end else begin
         // shallow stop keeps driving from retained logic
         // port values at reset state when not restored
         for (int i = 0; i < `SMPC_PINS; i++) begin
            next_r.pad_out[i] = periph_en[i] ? periph_out[i] : port_out[i];
            next_r.pad_oe[i]  = periph_en[i] ? periph_oe[i]  : port_oe[i];
         end
      end
   end

   // ************************************************************
   // state register
   // ************************************************************
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         r       <= '0;
         r.state <= SMPC_RUN;
         r.ctrl  <= `SMPC_CTL_RESET;
      end else begin
         r <= next_r;
      end
   end

   // outputs straight from the state register, except hreadyout and hresp which are tied constant
   assign hrdata            = r.hrdata;
   assign hreadyout         = 1'b1;
   assign hresp             = 1'b0;
   assign pad_out           = r.pad_out;
   assign pad_oe            = r.pad_oe;
   assign core_power_off    = r.core_power_off;
   assign regulator_standby = r.regulator_standby;
   assign adc_standby       = r.adc_standby;
   assign clock_halt        = r.clock_halt;
   assign clock_gen_off     = r.clock_gen_off;
   assign cpu_reset         = r.cpu_reset;
   assign periph_reset      = r.periph_reset;
   assign wake_interrupt    = r.wake_interrupt;
   assign irq               = r.irq;

endmodule
`default_nettype wire

// >>> shared/smpc_cfg.svh
// offsets, field positions, reset values and timing counts of the stop mode power controller
`ifndef SMPC_CFG_SVH
`define SMPC_CFG_SVH

// ************************************************************
// register byte offsets
// ************************************************************
`define SMPC_OFS_CONTROL          8'h00
`define SMPC_OFS_PMSC2            8'h04
`define SMPC_OFS_INT_STATUS       8'h08
`define SMPC_OFS_INT_CLEAR        8'h0C
`define SMPC_OFS_INT_ENABLE       8'h10

// ************************************************************
// control register fields
// ************************************************************
`define SMPC_CTL_DEEP_SEL         0
`define SMPC_CTL_LVD_EN           1
`define SMPC_CTL_LVD_STOP_EN      2
`define SMPC_CTL_RATE_LO          3
`define SMPC_CTL_RATE_HI          5
`define SMPC_CTL_IRQ_HIGH         6
`define SMPC_CTL_WIDTH            7
`define SMPC_CTL_RESET            7'h06

// ************************************************************
// power mode status control two fields
// ************************************************************
`define SMPC_PM_WAKE_FLAG         0
`define SMPC_PM_ACK               1
`define SMPC_PM_LATCHED           2

// ************************************************************
// interrupt status bits
// ************************************************************
`define SMPC_EV_DEEP_WAKE         0
`define SMPC_EV_SHALLOW_WAKE      1
`define SMPC_EV_REFUSED           2
`define SMPC_EV_RTI               3
`define SMPC_EV_WIDTH             4

// ************************************************************
// widths and timing
// ************************************************************
`define SMPC_PINS                 8
`define SMPC_CLK_PERIOD_PS        4000
`define SMPC_RTI_OSC_PERIOD_US    1000
`define SMPC_RTI_OSC_CYCLES       ((`SMPC_RTI_OSC_PERIOD_US * 1000000) / `SMPC_CLK_PERIOD_PS)
`define SMPC_OSC_CNT_W            18
`define SMPC_RTI_CNT_W            10

`endif

// >>> shared/smpc_pkg.sv
// types of the stop mode power controller
package smpc_pkg;

   // power state, one-hot
   typedef enum logic [3:0] {
      SMPC_RUN     = 4'b0001,
      SMPC_DEEP    = 4'b0010,
      SMPC_SHALLOW = 4'b0100,
      SMPC_RESTART = 4'b1000
   } smpc_state_e;

   // complete state of the top module
   typedef struct packed {
      smpc_state_e state;
      logic [6:0]  ctrl;
      logic        wake_flag;
      logic        latched;
      logic [7:0]  latch_out;
      logic [7:0]  latch_oe;
      logic [3:0]  int_status;
      logic [3:0]  int_enable;
      logic        wr_pend;
      logic [7:0]  wr_addr;
      logic [31:0] hrdata;
      logic        irq;
      logic        core_power_off;
      logic        regulator_standby;
      logic        adc_standby;
      logic        clock_halt;
      logic        clock_gen_off;
      logic        cpu_reset;
      logic        periph_reset;
      logic        wake_interrupt;
      logic [7:0]  pad_out;
      logic [7:0]  pad_oe;
   } smpc_state_s;

endpackage
